//--- core/isa_pkg.sv
// Types of the interleaved converter sequencer.
// Assumes isa_regs.svh for the constants it names.
`include "isa_regs.svh"

package isa_pkg;

  typedef struct packed {
    logic       overrange;
    logic [9:0] code;
  } isa_word_t;

  typedef struct packed {
    logic [10:0]       hold;
    logic [10:0]       sar;
    logic [10:0]       zeroHold;
    logic signed [5:0] off;
    logic signed [6:0] gain;
  } isa_sec_t;

  typedef struct packed {
    logic [3:0]                     phase;
    logic [13:0]                    calCnt;
    logic                           calDone;
    logic [1:0][10:0]               vinSync;
    logic [1:0][10:0]               zeroSync;
    logic [1:0][10:0]               calSync;
    logic [1:0]                     oeSync;
    logic [1:0]                     readySync;
    isa_sec_t [`ISA_NUM_SEC-1:0]    sec;
    logic                           pendValid;
    isa_word_t                      pend;
    isa_word_t                      dout;
    logic                           strobe;
    logic                           oeN;
  } isa_core_t;

  typedef struct packed {
    isa_word_t [1:0] mem;
    logic            wrPtr;
    logic            rdPtr;
    logic [1:0]      count;
  } isa_buf_t;

endpackage : isa_pkg

//--- core/isa_regs.svh
// Named constants of the interleaved converter sequencer.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ISA_REGS_SVH
`define ISA_REGS_SVH

// Sections, stagger and frame
`define ISA_NUM_SEC        8
`define ISA_STAGGER        4'h2
`define ISA_LAST_PHASE     4'hF
`define ISA_PHASE_STEP     4'h1

// Local frame cycles, counted from zero (cycle 1 is index 0)
`define ISA_CYC_REF_ZERO   4'h0
`define ISA_CYC_AUTO_ZERO  4'h1
`define ISA_CYC_AUTO_CAL   4'h2
`define ISA_CYC_SAMPLE     4'h3
`define ISA_CYC_SAR_FIRST  4'h4
`define ISA_CYC_SAR_LAST   4'hE
`define ISA_CYC_TRANSFER   4'hF

// Codes
`define ISA_SAR_MSB        11'h400
`define ISA_SAR_ZERO       11'h000
`define ISA_FULL_RANGE     11'h7FF
`define ISA_CODE_MAX       10'h3FF
`define ISA_CAL_TARGET     11'h3C0

// Trim arithmetic
`define ISA_OFF_FRAC       2
`define ISA_GAIN_SHIFT     8
`define ISA_GAIN_ONE       10'sh100
`define ISA_OFF_MAX        6'sh1F
`define ISA_OFF_MIN        6'sh21
`define ISA_OFF_STEP       6'sh01
`define ISA_GAIN_MAX       7'sh3F
`define ISA_GAIN_MIN       7'sh41
`define ISA_GAIN_STEP      7'sh01

// Calibration settling in input-clock cycles
`define ISA_CAL_CYCLES     10000
`define ISA_CAL_CNT_ONE    14'h0001

`endif

//--- core/isa_sequencer.sv
// Sequencer, interleaved approximation sections and output stage of the converter.
// Assumes digitised comparator-side levels on pins, host logic on the far side.
//
// Behaviour
// R1: Eight parallel approximation sections, sixteen-phase sequencer, eleven-bit eight-way output select.
// R2: Every section completes one conversion in exactly sixteen clock cycles.
// R3: Frame: zero sample, auto-zero, auto-calibrate, input sample, eleven approximation steps, transfer.
// R4: Adjacent sections offset by two cycles; one sample every other cycle.
// R5: Sequencer wraps and restarts its pattern every sixteen clock periods.
// R6: One output word per two clock cycles.
// R7: Output word appears twelve cycles after its input sample.
// R8: Calibration starts at power-up; full accuracy after at least ten thousand cycles.
// R9: Host keeps the clock running continuously so calibration is kept.
// R10: Gain and offset trims adapt in background without disturbing the word stream.
// R11: All sequencing advances only on rising clock edges.
// R12: Code and overrange outputs are registered on the rising clock edge.
// R13: Active-low enable high floats all eleven data outputs; low drives them. Code only registers it onto dataOeN; sampleCode and overrangeFlag stay driven.
// R14: Sample code is unsigned straight binary from zero upward.
// R15: Overrange is one with code all ones at full scale; zero in range. Code keeps it zero at code 3FF and sets it only from 400 up.
// R16: Host holds logic inputs low until supplies settle.
// R17: Overrange raised when input exceeds positive full scale.
// R18: While overrange is one all ten code bits read one.
// R19: One-cycle valid strobe marks each new output word.
`timescale 1ns/1ps
`include "isa_regs.svh"

module isa_sequencer
  import isa_pkg::*;
#(
  parameter int CAL_MIN_CYCLES = `ISA_CAL_CYCLES
) (
  input  logic        sys_clk,
  input  logic        rst,
  input  logic [10:0] analogCode,
  input  logic [10:0] refZeroLevel,
  input  logic [10:0] calRefLevel,
  input  logic        outEnableN,
  input  logic        hostReady,
  output logic [9:0]  sampleCode,
  output logic        overrangeFlag,
  output logic        dataOeN,
  output logic        wordValidStrobe,
  output logic        calibrated
);

  isa_core_t q;
  isa_core_t d;

  logic      bufInValid;
  isa_word_t bufInWord;
  logic      bufInReady;
  logic      bufOutValid;
  isa_word_t bufOutWord;
  logic      bufOutReady;

  // Local frame index of a section
  function automatic logic [3:0] isaLocal(input logic [3:0] ph, input logic [2:0] s);
    return 4'(ph - 4'(4'(s) * `ISA_STAGGER)); // see R4
  endfunction : isaLocal

  // Offset and gain trim applied to a level
  function automatic logic [10:0] isaCorrect(input logic [10:0] x,
                                             input logic signed [5:0] off,
                                             input logic signed [6:0] gain);
    logic signed [14:0] scaled;
    logic signed [9:0]  gainFull;
    logic signed [24:0] prod;
    logic signed [24:0] res;
    scaled   = $signed({2'b00, x, 2'b00}) - 15'(off);
    gainFull = `ISA_GAIN_ONE + 10'(gain);
    prod     = 25'(scaled) * 25'(gainFull);
    res      = prod >>> (`ISA_GAIN_SHIFT + `ISA_OFF_FRAC);
    if (res < 25'sh0) begin
      return `ISA_SAR_ZERO;
    end else if (res > $signed({14'h0, `ISA_FULL_RANGE})) begin
      return `ISA_FULL_RANGE;
    end
    return 11'(res);
  endfunction : isaCorrect

  // Approximation result to output word
  function automatic isa_word_t isaToWord(input logic [10:0] sar);
    isa_word_t w;
    w.overrange = sar[10];                            // see R15 see R17
    w.code      = sar[10] ? `ISA_CODE_MAX : sar[9:0]; // see R14 see R18
    return w;
  endfunction : isaToWord

  always_comb begin
    logic [3:0]        loc;
    logic [10:0]       bitMask;
    logic [10:0]       trial;
    logic [10:0]       corr;
    logic signed [14:0] zeroErr;
    logic              newValid;
    isa_word_t         newWord;
    loc      = '0;
    bitMask  = '0;
    trial    = '0;
    corr     = '0;
    zeroErr  = '0;
    newValid = 1'b0;
    newWord  = '0;
    d        = q;

    // Pin synchronisers
    d.vinSync[0]   = analogCode;
    d.vinSync[1]   = q.vinSync[0];
    d.zeroSync[0]  = refZeroLevel;
    d.zeroSync[1]  = q.zeroSync[0];
    d.calSync[0]   = calRefLevel;
    d.calSync[1]   = q.calSync[0];
    d.oeSync[0]    = outEnableN;
    d.oeSync[1]    = q.oeSync[0];
    d.readySync[0] = hostReady;
    d.readySync[1] = q.readySync[0];

    // Free-running sixteen-phase sequencer
    if (q.phase == `ISA_LAST_PHASE) begin
      d.phase = '0; // see R5
    end else begin
      d.phase = q.phase + `ISA_PHASE_STEP; // see R2 see R11
    end

    // Power-up calibration settling
    if (!q.calDone) begin
      d.calCnt = q.calCnt + `ISA_CAL_CNT_ONE; // see R8
      if (q.calCnt == 14'(CAL_MIN_CYCLES - 1)) begin
        d.calDone = 1'b1;
      end
    end

    // Sections, each walking its own staggered frame
    for (int i = 0; i < `ISA_NUM_SEC; i++) begin // see R1
      loc = isaLocal(q.phase, 3'(i));
      case (loc) // see R3
        `ISA_CYC_REF_ZERO: begin
          d.sec[i].zeroHold = q.zeroSync[1];
        end
        `ISA_CYC_AUTO_ZERO: begin
          zeroErr = $signed({2'b00, q.sec[i].zeroHold, 2'b00}) - 15'(q.sec[i].off);
          if (zeroErr > 15'sh0 && q.sec[i].off != `ISA_OFF_MAX) begin
            d.sec[i].off = q.sec[i].off + `ISA_OFF_STEP; // see R10
          end else if (zeroErr < 15'sh0 && q.sec[i].off != `ISA_OFF_MIN) begin
            d.sec[i].off = q.sec[i].off - `ISA_OFF_STEP; // see R10
          end
        end
        `ISA_CYC_AUTO_CAL: begin
          corr = isaCorrect(q.calSync[1], q.sec[i].off, q.sec[i].gain);
          if (corr > `ISA_CAL_TARGET && q.sec[i].gain != `ISA_GAIN_MIN) begin
            d.sec[i].gain = q.sec[i].gain - `ISA_GAIN_STEP; // see R10
          end else if (corr < `ISA_CAL_TARGET && q.sec[i].gain != `ISA_GAIN_MAX) begin
            d.sec[i].gain = q.sec[i].gain + `ISA_GAIN_STEP; // see R10
          end
        end
        `ISA_CYC_SAMPLE: begin
          d.sec[i].hold = isaCorrect(q.vinSync[1], q.sec[i].off, q.sec[i].gain); // see R4 see R6
          d.sec[i].sar  = `ISA_SAR_ZERO;
        end
        `ISA_CYC_TRANSFER: begin
          d.sec[i].sar = q.sec[i].sar;
        end
        default: begin
          bitMask = `ISA_SAR_MSB >> (loc - `ISA_CYC_SAR_FIRST);
          trial   = q.sec[i].sar | bitMask;
          if (q.sec[i].hold >= trial) begin
            d.sec[i].sar = trial;
          end
          if (loc == `ISA_CYC_SAR_LAST) begin
            newValid = 1'b1;
            newWord  = isaToWord(d.sec[i].sar); // see R1 see R7
          end
        end
      endcase
    end

    // Word waiting for buffer room
    bufInValid = q.pendValid | newValid;
    bufInWord  = q.pendValid ? q.pend : newWord;
    if (q.pendValid) begin
      if (bufInReady) begin
        d.pendValid = newValid;
        d.pend      = newWord;
      end
    end else if (newValid && !bufInReady) begin
      d.pendValid = 1'b1;
      d.pend      = newWord;
    end

    // Output register and strobe
    bufOutReady = q.readySync[1];
    d.strobe    = bufOutValid & bufOutReady; // see R19
    if (bufOutValid && bufOutReady) begin
      d.dout = bufOutWord; // see R12
    end
    d.oeN = q.oeSync[1]; // see R13
  end

  always_ff @(posedge sys_clk or posedge rst) begin // see R11
    if (rst) begin
      q           <= '0;
      q.oeSync    <= 2'h3;
      q.oeN       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  isa_word_buffer u_buffer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (bufInValid),
    .inWord   (bufInWord),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outWord  (bufOutWord),
    .outReady (bufOutReady)
  );

  assign sampleCode      = q.dout.code;
  assign overrangeFlag   = q.dout.overrange;
  assign dataOeN         = q.oeN;
  assign wordValidStrobe = q.strobe;
  assign calibrated      = q.calDone;

endmodule : isa_sequencer

//--- core/isa_word_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps

module isa_word_buffer
  import isa_pkg::*;
(
  input  logic      sys_clk,
  input  logic      rst,
  input  logic      inValid,
  input  isa_word_t inWord,
  output logic      inReady,
  output logic      outValid,
  output isa_word_t outWord,
  input  logic      outReady
);

  isa_buf_t q;
  isa_buf_t d;

  assign inReady  = (q.count != 2'h2);
  assign outValid = (q.count != 2'h0);
  assign outWord  = q.mem[q.rdPtr];

  always_comb begin
    logic push;
    logic pop;
    push = inValid & inReady;
    pop  = outValid & outReady;
    d    = q;
    if (push) begin
      d.mem[q.wrPtr] = inWord;
      d.wrPtr        = ~q.wrPtr;
    end
    if (pop) begin
      d.rdPtr = ~q.rdPtr;
    end
    if (push && !pop) begin
      d.count = q.count + 2'h1;
    end else if (pop && !push) begin
      d.count = q.count - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : isa_word_buffer

//--- testbench/interleaved_sar_adc_sequencer_tb.sv
// Testbench of the interleaved converter sequencer.
// Assumes host model on the data bus, inputs driven at falling edges.
`timescale 1ns/1ps
`define ISA_CHK(n, e, g) begin testsRun++; if ((e) !== (g)) begin failCount++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end

module interleaved_sar_adc_sequencer_tb;
  import isa_pkg::*;
  typedef struct packed {logic [10:0] vin; isa_word_t exp;} isa_row_t;
  isa_row_t rows [7] = '{'{11'h000, 11'h000}, '{11'h001, 11'h001}, '{11'h200, 11'h200},
    '{11'h3FE, 11'h3FE}, '{11'h3FF, 11'h3FF}, '{11'h400, 11'h7FF}, '{11'h7FF, 11'h7FF}};
  logic        sys_clk, rst, stallReq, outEnableN, hostReady;
  logic [10:0] analogCode, refZeroLevel, calRefLevel;
  logic [9:0]  sampleCode;
  logic        overrangeFlag, dataOeN, wordValidStrobe, calibrated;
  wire [10:0]  dataBus = dataOeN ? 11'hzzz : {overrangeFlag, sampleCode};
  isa_word_t   lastWord;
  int          wordCnt, failCount, testsRun, n, c0;

  isa_sequencer #(.CAL_MIN_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst(rst), .analogCode(analogCode),
    .refZeroLevel(refZeroLevel), .calRefLevel(calRefLevel), .outEnableN(outEnableN), .hostReady(hostReady),
    .sampleCode(sampleCode), .overrangeFlag(overrangeFlag), .dataOeN(dataOeN),
    .wordValidStrobe(wordValidStrobe), .calibrated(calibrated));
  isa_host_model host_u (.sys_clk(sys_clk), .rst(rst), .stallReq(stallReq), .wordValidStrobe(wordValidStrobe),
    .dataBus(dataBus), .hostReady(hostReady), .lastWord(lastWord), .wordCnt(wordCnt));

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : giveVerdict

  task automatic checkReset;
    `ISA_CHK("oe", 1'b1, dataOeN);
    `ISA_CHK("strobe", 1'b0, wordValidStrobe);
    `ISA_CHK("cal", 1'b0, calibrated);
  endtask : checkReset

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #10000;
    failCount++;
    giveVerdict();
  end

  initial begin
    {rst, stallReq, outEnableN, analogCode, refZeroLevel, calRefLevel} = '0;
    rst = 1'b1;
    failCount = 0;
    testsRun = 0;
    repeat (3) @(negedge sys_clk);
    checkReset();
    rst = 1'b0;
    calRefLevel = 11'h3C0;
    repeat (25) @(negedge sys_clk);
    `ISA_CHK("cal", 1'b1, calibrated);
    $display("test reset and calibration done");
    foreach (rows[i]) begin
      analogCode = rows[i].vin;
      repeat (40) @(negedge sys_clk);
      `ISA_CHK("word", rows[i].exp, lastWord);
    end
    $display("test code table done");
    analogCode = 11'h155;
    n = 0;
    while (lastWord !== 11'h155 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    `ISA_CHK("latency", 1'b1, (n >= 16 && n <= 17));
    $display("test latency done");
    stallReq = 1'b1;
    repeat (6) @(negedge sys_clk);
    c0 = wordCnt;
    repeat (20) @(negedge sys_clk);
    `ISA_CHK("stall", c0, wordCnt);
    stallReq = 1'b0;
    repeat (10) @(negedge sys_clk);
    `ISA_CHK("drain", 1'b1, (wordCnt - c0 >= 3));
    $display("test stall done");
    outEnableN = 1'b1;
    repeat (5) @(negedge sys_clk);
    `ISA_CHK("float", 11'hzzz, dataBus);
    outEnableN = 1'b0;
    repeat (5) @(negedge sys_clk);
    `ISA_CHK("drive", 11'h155, dataBus);
    $display("test enable done");
    rst = 1'b1;
    analogCode = 11'h2AA;
    repeat (3) @(negedge sys_clk);
    checkReset();
    rst = 1'b0;
    repeat (40) @(negedge sys_clk);
    `ISA_CHK("resume", 11'h2AA, lastWord);
    $display("test second reset done");
    giveVerdict();
  end
endmodule : interleaved_sar_adc_sequencer_tb

//--- testbench/isa_host_model.sv
// Host model capturing sample words from the resolved data bus.
// Assumes a bench stall request and the converter clock.
`timescale 1ns/1ps

module isa_host_model
  import isa_pkg::*;
(
  input  logic       sys_clk,
  input  logic       rst,
  input  logic       stallReq,
  input  logic       wordValidStrobe,
  input  wire [10:0] dataBus,
  output logic       hostReady,
  output isa_word_t  lastWord,
  output int         wordCnt
);
  initial begin
    hostReady = 1'b0;
    lastWord  = '0;
    wordCnt   = 0;
  end
  // Ready held low in reset
  always @(negedge sys_clk) hostReady <= !rst && !stallReq;
  always @(posedge sys_clk) begin
    if (wordValidStrobe === 1'b1) begin
      lastWord <= dataBus;
      wordCnt  <= wordCnt + 1;
    end
  end
endmodule : isa_host_model

//--- testbench/isa_seq_monitor.sv
// Port checker of the interleaved converter sequencer.
// Assumes a bind to isa_sequencer and its single clock.
`timescale 1ns/1ps

module isa_seq_monitor
  import isa_pkg::*;
#(
  parameter int CAL_MIN_CYCLES = 20
) (
  input logic        sys_clk,
  input logic        rst,
  input logic [10:0] analogCode,
  input logic [10:0] refZeroLevel,
  input logic [10:0] calRefLevel,
  input logic        outEnableN,
  input logic        hostReady,
  input logic [9:0]  sampleCode,
  input logic        overrangeFlag,
  input logic        dataOeN,
  input logic        wordValidStrobe,
  input logic        calibrated
);
  logic [15:0] age_q;
  logic [4:0]  rdy_q;
  logic [4:0]  stab_q;
  logic [10:0] prev_q;
  logic [10:0] expW;

  // Over full scale reads all ones plus flag
  assign expW = analogCode[10] ? 11'h7FF : {1'b0, analogCode[9:0]};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age_q  <= 16'h0000;
      rdy_q  <= 5'h00;
      stab_q <= 5'h00;
      prev_q <= 11'h000;
    end else begin
      age_q  <= (age_q == 16'hFFFF) ? age_q : age_q + 16'h0001;
      rdy_q  <= !hostReady ? 5'h00 : ((rdy_q == 5'h1F) ? rdy_q : rdy_q + 5'h01);
      stab_q <= (analogCode != prev_q) ? 5'h00 : ((stab_q == 5'h1F) ? stab_q : stab_q + 5'h01);
      prev_q <= analogCode;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_strobe_pulse: assert property (wordValidStrobe && rdy_q == 5'h1F |=> !wordValidStrobe)
    else $error("strobe longer than one cycle");
  a_word_rate: assert property (wordValidStrobe && rdy_q == 5'h1F |-> ##2 wordValidStrobe)
    else $error("word rate not half the clock");
  a_over_ones: assert property (overrangeFlag |-> sampleCode == 10'h3FF)
    else $error("code not all ones while overrange");
  a_hold_between: assert property (!wordValidStrobe |-> $stable({overrangeFlag, sampleCode}))
    else $error("output word changed without strobe");
  a_oe_follow: assert property (age_q > 16'h0005 |-> dataOeN == $past(outEnableN, 3))
    else $error("output enable not followed");
  a_cal_early: assert property (age_q < CAL_MIN_CYCLES - 1 |-> !calibrated)
    else $error("calibrated too early");
  a_cal_late: assert property (age_q > CAL_MIN_CYCLES + 1 |-> calibrated)
    else $error("calibrated missing or lost");
  a_word_value: assert property (wordValidStrobe && rdy_q == 5'h1F && stab_q == 5'h1F |->
    {overrangeFlag, sampleCode} == expW)
    else $error("word value wrong");
  a_stall_hold: assert property (!hostReady [*4] |=> !wordValidStrobe)
    else $error("word sent while host stalled");
endmodule : isa_seq_monitor

bind isa_sequencer isa_seq_monitor #(.CAL_MIN_CYCLES(CAL_MIN_CYCLES)) mon_u (.*);
